/* src/psm_pin_mux.sv */
`timescale 1ns/1ps
// Contract
// - Capture cell, PCI and autoinit straps when the settle count runs out after reset release; port-2 select is followed live, not captured.
// - Cell select 0: serial port 1 owns shared pins, cell solo pins Hi-Z.
// - Cell select 1: cell port owns shared pins, serial port 1 solo pins Hi-Z.
// - PCI select 0: host port owns shared host/PCI pins, upper pins usable as GPIO.
// - PCI deselected: byte-enable-0 and EEPROM chip-select pins held Hi-Z.
// - PCI deselected: upper pin is GPIO per its enable bit, driven only when its enable and direction bits are both set.
// - PCI select 1: host port disabled, shared host/PCI pins belong to PCI.
// - PCI select 1: upper pins serve PCI, not GPIO.
// - Serial port 2 off and EEPROM on only when PCI is 1 and port-2 select 0.
// - PCI, port 2 off and autoinit strap 1: start EEPROM load when the straps are captured after reset release.
// - Port-2 select rising after reset enables port 2 and stops EEPROM, no reset.
// - Timers, serial port 0, lower GPIO and coprocessors are always available.
// - Autoinit strap 0 disables EEPROM load; 1 loads when EEPROM pins enabled.
module psm_pin_mux
	import psm_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic cfg_strap_cell_select_pin,
	input wire logic pci_select_pin,
	input wire logic serial_port2_select,
	input wire logic cfg_strap_eeprom_pin,
	input wire logic [GP_UPPER_W-1:0] gpio_pin_enable_bit,
	input wire logic [GP_UPPER_W-1:0] gpio_pin_direction_bit,
	input wire logic [GP_UPPER_W-1:0] gpio_upper_out,
	input wire logic [GP_UPPER_W-1:0] pci_upper_out,
	input wire logic [GP_UPPER_W-1:0] pci_upper_oe,
	input wire logic [CS_SHARED_W-1:0] sp1_shared_out,
	input wire logic [CS_SHARED_W-1:0] sp1_shared_oe,
	input wire logic [CS_SHARED_W-1:0] cell_shared_out,
	input wire logic [CS_SHARED_W-1:0] cell_shared_oe,
	input wire logic [CELL_SOLO_W-1:0] cell_solo_out,
	input wire logic [SP1_SOLO_W-1:0] sp1_solo_out,
	input wire logic [HP_SHARED_W-1:0] host_shared_out,
	input wire logic [HP_SHARED_W-1:0] host_shared_oe,
	input wire logic [HP_SHARED_W-1:0] pci_shared_out,
	input wire logic [HP_SHARED_W-1:0] pci_shared_oe,
	input wire logic pci_be0_out,
	input wire logic pci_be0_drive,
	input wire logic eeprom_cs_out,
	output logic cfg_valid,
	output logic cell_port_enable,
	output logic serial_port1_enable,
	output logic host_port_enable,
	output logic pci_enable,
	output logic serial_port2_enable,
	output logic eeprom_enable,
	output logic eeprom_load_start,
	output logic core_periph_enable,
	output logic [GP_UPPER_W-1:0] gpio_upper_is_gpio,
	output logic [CS_SHARED_W-1:0] cs_shared_pin_o,
	output logic [CS_SHARED_W-1:0] cs_shared_pin_oe,
	output logic [CELL_SOLO_W-1:0] cell_solo_pin_o,
	output logic [CELL_SOLO_W-1:0] cell_solo_pin_oe,
	output logic [SP1_SOLO_W-1:0] sp1_solo_pin_o,
	output logic [SP1_SOLO_W-1:0] sp1_solo_pin_oe,
	output logic [HP_SHARED_W-1:0] hp_shared_pin_o,
	output logic [HP_SHARED_W-1:0] hp_shared_pin_oe,
	output logic [GP_UPPER_W-1:0] gp_upper_pin_o,
	output logic [GP_UPPER_W-1:0] gp_upper_pin_oe,
	output logic pci_be0_pin_o,
	output logic pci_be0_pin_oe,
	output logic eeprom_cs_pin_o,
	output logic eeprom_cs_pin_oe
);

	psm_state_e state_r, state_nxt;
	logic [1:0] settle_r, settle_nxt;
	logic cell_sel_r, cell_sel_nxt;
	logic pci_sel_r, pci_sel_nxt;
	logic eeprom_autoinit_strap_r, eeprom_autoinit_strap_nxt;
	logic sp2_meta_r, sp2_sync_r;
	logic load_r, load_nxt;
	logic valid;
	logic sp2_on;

	// The port-2 select is the only strap that may move in operation.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sp2_meta_r <= SP2_SEL_RST;
			sp2_sync_r <= SP2_SEL_RST;
		end else begin
			sp2_meta_r <= serial_port2_select;
			sp2_sync_r <= sp2_meta_r;
		end
	end

	// Straps are taken once the settle count has run out after release, so the
	// synchronised port-2 select is already valid when the load decision is made.
	always_comb begin
		state_nxt = state_r;
		settle_nxt = settle_r;
		cell_sel_nxt = cell_sel_r;
		pci_sel_nxt = pci_sel_r;
		eeprom_autoinit_strap_nxt = eeprom_autoinit_strap_r;
		load_nxt = 1'b0;
		case (state_r)
			PSM_SETTLE: begin
				if (settle_r == STRAP_SETTLE_CYC) begin
					state_nxt = PSM_RUN;
					cell_sel_nxt = cfg_strap_cell_select_pin;
					pci_sel_nxt = pci_select_pin;
					eeprom_autoinit_strap_nxt = cfg_strap_eeprom_pin;
					load_nxt = pci_select_pin & ~sp2_sync_r & cfg_strap_eeprom_pin;
				end else begin
					settle_nxt = settle_r + 2'd1;
				end
			end
			PSM_RUN: begin
				state_nxt = PSM_RUN;
			end
			default: begin
				state_nxt = PSM_SETTLE;
				settle_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= PSM_SETTLE;
			settle_r <= '0;
			cell_sel_r <= CELL_SEL_RST;
			pci_sel_r <= PCI_SEL_RST;
			eeprom_autoinit_strap_r <= EEPROM_AUTOINIT_STRAP_RST;
			load_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			settle_r <= settle_nxt;
			cell_sel_r <= cell_sel_nxt;
			pci_sel_r <= pci_sel_nxt;
			eeprom_autoinit_strap_r <= eeprom_autoinit_strap_nxt;
			load_r <= load_nxt;
		end
	end

	assign valid = (state_r == PSM_RUN);
	assign sp2_on = ~pci_sel_r | sp2_sync_r;
	assign eeprom_load_start = load_r;

	// Registered enables and pin drivers; nothing drives a pin before capture.
	logic [7:0] en_r, en_nxt;
	logic [CS_SHARED_W-1:0] cs_o_nxt, cs_oe_nxt;
	logic [CELL_SOLO_W-1:0] cell_oe_nxt;
	logic [SP1_SOLO_W-1:0] sp1_oe_nxt;
	logic [HP_SHARED_W-1:0] hp_o_nxt, hp_oe_nxt;
	logic [GP_UPPER_W-1:0] gp_o_nxt, gp_oe_nxt, gp_is_nxt;
	logic be0_oe_nxt, cs_pin_oe_nxt;

	always_comb begin
		en_nxt = '0;
		cs_o_nxt = '0;
		cs_oe_nxt = '0;
		cell_oe_nxt = '0;
		sp1_oe_nxt = '0;
		hp_o_nxt = '0;
		hp_oe_nxt = '0;
		be0_oe_nxt = 1'b0;
		cs_pin_oe_nxt = 1'b0;
		en_nxt[7] = 1'b1;
		if (valid) begin
			en_nxt[0] = 1'b1;
			en_nxt[1] = cell_sel_r;
			en_nxt[2] = ~cell_sel_r;
			en_nxt[3] = ~pci_sel_r;
			en_nxt[4] = pci_sel_r;
			en_nxt[5] = sp2_on;
			en_nxt[6] = ~sp2_on;
			if (cell_sel_r) begin
				cs_o_nxt = cell_shared_out;
				cs_oe_nxt = cell_shared_oe;
				cell_oe_nxt = '1;
			end else begin
				cs_o_nxt = sp1_shared_out;
				cs_oe_nxt = sp1_shared_oe;
				sp1_oe_nxt = '1;
			end
			if (pci_sel_r) begin
				hp_o_nxt = pci_shared_out;
				hp_oe_nxt = pci_shared_oe;
				be0_oe_nxt = pci_be0_drive;
				cs_pin_oe_nxt = ~sp2_on;
			end else begin
				hp_o_nxt = host_shared_out;
				hp_oe_nxt = host_shared_oe;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < GP_UPPER_W; gi++) begin : g_upper
			always_comb begin
				gp_is_nxt[gi] = valid & ~pci_sel_r & gpio_pin_enable_bit[gi];
				if (!valid) begin
					gp_o_nxt[gi] = 1'b0;
					gp_oe_nxt[gi] = 1'b0;
				end else if (pci_sel_r) begin
					gp_o_nxt[gi] = pci_upper_out[gi];
					gp_oe_nxt[gi] = pci_upper_oe[gi];
				end else begin
					gp_o_nxt[gi] = gpio_upper_out[gi];
					gp_oe_nxt[gi] = gpio_pin_enable_bit[gi] & gpio_pin_direction_bit[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			en_r <= 8'h80;
			cs_shared_pin_o <= '0;
			cs_shared_pin_oe <= '0;
			cell_solo_pin_o <= '0;
			cell_solo_pin_oe <= '0;
			sp1_solo_pin_o <= '0;
			sp1_solo_pin_oe <= '0;
			hp_shared_pin_o <= '0;
			hp_shared_pin_oe <= '0;
			gp_upper_pin_o <= '0;
			gp_upper_pin_oe <= '0;
			gpio_upper_is_gpio <= '0;
			pci_be0_pin_o <= 1'b0;
			pci_be0_pin_oe <= 1'b0;
			eeprom_cs_pin_o <= 1'b0;
			eeprom_cs_pin_oe <= 1'b0;
		end else begin
			en_r <= en_nxt;
			cs_shared_pin_o <= cs_o_nxt;
			cs_shared_pin_oe <= cs_oe_nxt;
			cell_solo_pin_o <= cell_solo_out;
			cell_solo_pin_oe <= cell_oe_nxt;
			sp1_solo_pin_o <= sp1_solo_out;
			sp1_solo_pin_oe <= sp1_oe_nxt;
			hp_shared_pin_o <= hp_o_nxt;
			hp_shared_pin_oe <= hp_oe_nxt;
			gp_upper_pin_o <= gp_o_nxt;
			gp_upper_pin_oe <= gp_oe_nxt;
			gpio_upper_is_gpio <= gp_is_nxt;
			pci_be0_pin_o <= pci_be0_out;
			pci_be0_pin_oe <= be0_oe_nxt;
			eeprom_cs_pin_o <= eeprom_cs_out;
			eeprom_cs_pin_oe <= cs_pin_oe_nxt;
		end
	end

	assign cfg_valid = en_r[0];
	assign cell_port_enable = en_r[1];
	assign serial_port1_enable = en_r[2];
	assign host_port_enable = en_r[3];
	assign pci_enable = en_r[4];
	assign serial_port2_enable = en_r[5];
	assign eeprom_enable = en_r[6];
	assign core_periph_enable = en_r[7];

	strap_capture_a: assert property (@(posedge clk) disable iff (reset)
		$rose(valid) |-> cell_sel_r == $past(cfg_strap_cell_select_pin)
			&& eeprom_autoinit_strap_r == $past(cfg_strap_eeprom_pin))
		else $error("straps not captured at settle end");
	cell_off_hiz_a: assert property (@(posedge clk) disable iff (reset)
		valid && !cell_sel_r |=> cell_solo_pin_oe == '0 && serial_port1_enable
			&& cs_shared_pin_oe == $past(sp1_shared_oe))
		else $error("cell solo pins driven or port 1 not owner");
	sp1_off_hiz_a: assert property (@(posedge clk) disable iff (reset)
		valid && cell_sel_r |=> sp1_solo_pin_oe == '0 && cell_port_enable
			&& cs_shared_pin_o == $past(cell_shared_out))
		else $error("port 1 solo pins driven or cell port not owner");
	host_owner_a: assert property (@(posedge clk) disable iff (reset)
		valid && !pci_sel_r |=> host_port_enable && !pci_enable
			&& hp_shared_pin_oe == $past(host_shared_oe))
		else $error("host port does not own shared pins");
	pci_solo_hiz_a: assert property (@(posedge clk) disable iff (reset)
		valid && !pci_sel_r |=> !pci_be0_pin_oe && !eeprom_cs_pin_oe)
		else $error("PCI solo pin driven while PCI off");
	gpio_cfg_a: assert property (@(posedge clk) disable iff (reset)
		valid && !pci_sel_r |=> gp_upper_pin_oe
			== ($past(gpio_pin_enable_bit) & $past(gpio_pin_direction_bit)))
		else $error("upper pin drive ignores enable and direction");
	pci_owner_a: assert property (@(posedge clk) disable iff (reset)
		valid && pci_sel_r |=> !host_port_enable
			&& hp_shared_pin_o == $past(pci_shared_out))
		else $error("PCI does not own shared pins");
	upper_pci_a: assert property (@(posedge clk) disable iff (reset)
		valid && pci_sel_r |=> gpio_upper_is_gpio == '0
			&& gp_upper_pin_oe == $past(pci_upper_oe))
		else $error("upper pins left as GPIO under PCI");
	sp2_select_a: assert property (@(posedge clk) disable iff (reset)
		valid |=> serial_port2_enable == !eeprom_enable
			&& eeprom_enable == ($past(pci_sel_r) && !$past(sp2_sync_r)))
		else $error("port 2 and EEPROM selection wrong");
	autoinit_a: assert property (@(posedge clk) disable iff (reset)
		eeprom_load_start |-> $past(pci_select_pin) && $past(cfg_strap_eeprom_pin)
			&& !$past(sp2_sync_r) ##1 !eeprom_load_start[*2])
		else $error("EEPROM load start wrong");
	sp2_dyn_a: assert property (@(posedge clk) disable iff (reset)
		valid && $rose(serial_port2_select) |-> ##3 serial_port2_enable
			&& !eeprom_enable)
		else $error("port 2 not enabled three cycles after select");
	core_on_a: assert property (@(posedge clk) disable iff (reset)
		core_periph_enable)
		else $error("core peripherals disabled");
	sync_delay_a: assert property (@(posedge clk) disable iff (reset)
		$changed(sp2_sync_r) |-> sp2_sync_r == $past(serial_port2_select, 2))
		else $error("port 2 select not two stages");
	eeprom_autoinit_strap_off_a: assert property (@(posedge clk) disable iff (reset)
		$rose(valid) && !eeprom_autoinit_strap_r |-> !eeprom_load_start)
		else $error("EEPROM loaded with autoinit strap low");

	cell_mode_c: cover property (@(posedge clk) disable iff (reset)
		valid && cell_sel_r ##1 cell_port_enable);
	eeprom_load_c: cover property (@(posedge clk) disable iff (reset)
		eeprom_load_start);
	sp2_switch_c: cover property (@(posedge clk) disable iff (reset)
		eeprom_enable ##[1:20] serial_port2_enable);
	gpio_mode_c: cover property (@(posedge clk) disable iff (reset)
		valid && !pci_sel_r ##1 gp_upper_pin_oe != '0);

endmodule

/* src/psm_pkg.sv */
package psm_pkg;

	// Pin group widths of the multiplexed groups.
	localparam int CS_SHARED_W = 4;
	localparam int CELL_SOLO_W = 2;
	localparam int SP1_SOLO_W = 2;
	localparam int HP_SHARED_W = 8;
	localparam int GP_UPPER_W = 7;

	// Settling time for the straps after reset release, and its cycle count.
	localparam int CLK_PERIOD_PS = 5000;
	localparam int STRAP_SETTLE_PS = 10000;
	localparam int STRAP_SETTLE_CYC_I = (STRAP_SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [1:0] STRAP_SETTLE_CYC = 2'(STRAP_SETTLE_CYC_I);

	// Values that the latched straps hold before capture, and the reset value of the port-2 select synchronizer.
	localparam logic CELL_SEL_RST = 1'b0;
	localparam logic PCI_SEL_RST = 1'b0;
	localparam logic SP2_SEL_RST = 1'b0;
	localparam logic EEPROM_AUTOINIT_STRAP_RST = 1'b0;

	typedef enum logic [1:0] {
		PSM_SETTLE = 2'b01,
		PSM_RUN = 2'b10
	} psm_state_e;

endpackage

/* test/psm_strap_model.sv */
`timescale 1ns/1ps
// Board straps and system controller that drive the selection pins.
module psm_strap_model (
	input wire logic reset,
	input wire logic cell_want,
	input wire logic pci_want,
	input wire logic sp2_want,
	input wire logic eeprom_autoinit_strap_want,
	output logic cfg_strap_cell_select_pin,
	output logic pci_select_pin,
	output logic serial_port2_select,
	output logic cfg_strap_eeprom_pin
);
	// The PCI strap follows the request only under reset, so it is frozen in operation.
	always_latch begin
		if (reset) begin
			pci_select_pin <= pci_want;
		end
	end
	assign serial_port2_select = sp2_want;
	assign cfg_strap_cell_select_pin = cell_want;
	assign cfg_strap_eeprom_pin = eeprom_autoinit_strap_want;
endmodule

/* test/peripheral_select_pin_mux_bench.sv */
`timescale 1ns/1ps
module peripheral_select_pin_mux_bench;
	import psm_pkg::*;
	logic clk;
	logic reset = 1'b1;
	logic cell_w = 1'b0, pci_w = 1'b0, sp2_w = 1'b0, eeprom_autoinit_strap_w = 1'b0;
	logic cfg_strap_cell_select_pin, pci_select_pin, serial_port2_select, cfg_strap_eeprom_pin;
	logic [6:0] gpio_pin_enable_bit = '0, gpio_pin_direction_bit = '0, gpio_upper_out = '0;
	logic [6:0] pci_upper_out = '0, pci_upper_oe = '0;
	logic [3:0] sp1_shared_out = '0, sp1_shared_oe = '0, cell_shared_out = '0, cell_shared_oe = '0;
	logic [1:0] cell_solo_out = '0, sp1_solo_out = '0;
	logic [7:0] host_shared_out = '0, host_shared_oe = '0, pci_shared_out = '0, pci_shared_oe = '0;
	logic pci_be0_out = 1'b0, pci_be0_drive = 1'b0, eeprom_cs_out = 1'b0;
	logic cfg_valid, cell_port_enable, serial_port1_enable, host_port_enable, pci_enable;
	logic serial_port2_enable, eeprom_enable, eeprom_load_start, core_periph_enable;
	logic [6:0] gpio_upper_is_gpio, gp_upper_pin_o, gp_upper_pin_oe;
	logic [3:0] cs_shared_pin_o, cs_shared_pin_oe;
	logic [1:0] cell_solo_pin_o, cell_solo_pin_oe, sp1_solo_pin_o, sp1_solo_pin_oe;
	logic [7:0] hp_shared_pin_o, hp_shared_pin_oe;
	logic pci_be0_pin_o, pci_be0_pin_oe, eeprom_cs_pin_o, eeprom_cs_pin_oe;
	int n_mismatch = 0;
	int tests_run = 0;
	int cycles = 0;

	psm_strap_model strap_u (.reset, .cell_want(cell_w), .pci_want(pci_w), .sp2_want(sp2_w),
		.eeprom_autoinit_strap_want(eeprom_autoinit_strap_w), .cfg_strap_cell_select_pin, .pci_select_pin,
		.serial_port2_select, .cfg_strap_eeprom_pin);

	psm_pin_mux dut_u (.clk, .reset, .cfg_strap_cell_select_pin, .pci_select_pin,
		.serial_port2_select, .cfg_strap_eeprom_pin, .gpio_pin_enable_bit,
		.gpio_pin_direction_bit, .gpio_upper_out, .pci_upper_out, .pci_upper_oe,
		.sp1_shared_out, .sp1_shared_oe, .cell_shared_out, .cell_shared_oe, .cell_solo_out,
		.sp1_solo_out, .host_shared_out, .host_shared_oe, .pci_shared_out, .pci_shared_oe,
		.pci_be0_out, .pci_be0_drive, .eeprom_cs_out, .cfg_valid, .cell_port_enable,
		.serial_port1_enable, .host_port_enable, .pci_enable, .serial_port2_enable,
		.eeprom_enable, .eeprom_load_start, .core_periph_enable, .gpio_upper_is_gpio,
		.cs_shared_pin_o, .cs_shared_pin_oe, .cell_solo_pin_o, .cell_solo_pin_oe,
		.sp1_solo_pin_o, .sp1_solo_pin_oe, .hp_shared_pin_o, .hp_shared_pin_oe,
		.gp_upper_pin_o, .gp_upper_pin_oe, .pci_be0_pin_o, .pci_be0_pin_oe,
		.eeprom_cs_pin_o, .eeprom_cs_pin_oe);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic end_sim();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Inputs move one nanosecond after the rising edge, where registered outputs are settled.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic start(input logic c, input logic p, input logic s, input logic e);
		int k;
		int pulses;
		reset = 1'b1;
		{cell_w, pci_w, sp2_w, eeprom_autoinit_strap_w} = {c, p, s, e};
		tick(16);
		chk("outputs in reset", 16'h0000, 16'({cfg_valid, cell_port_enable, serial_port1_enable,
			host_port_enable, pci_enable, serial_port2_enable, eeprom_enable}));
		chk("core in reset", 16'h0001, 16'(core_periph_enable));
		reset = 1'b0;
		pulses = 0;
		k = 0;
		while (cfg_valid !== 1'b1 && k < 10) begin
			tick(1);
			pulses += int'(eeprom_load_start === 1'b1);
			k++;
		end
		tick(1);
		pulses += int'(eeprom_load_start === 1'b1);
		chk("valid", 16'h0001, 16'(cfg_valid));
		chk("load pulses", 16'(p && !s && e), 16'(pulses));
	endtask

	task automatic check_cfg(input logic c, input logic p, input logic s);
		chk("cell en", 16'(c), 16'(cell_port_enable));
		chk("port1 en", 16'(!c), 16'(serial_port1_enable));
		chk("host en", 16'(!p), 16'(host_port_enable));
		chk("pci en", 16'(p), 16'(pci_enable));
		chk("port2 en", 16'(!(p && !s)), 16'(serial_port2_enable));
		chk("eeprom en", 16'(p && !s), 16'(eeprom_enable));
		chk("eeprom cs oe", 16'(p && !s), 16'(eeprom_cs_pin_oe));
		chk("core en", 16'h0001, 16'(core_periph_enable));
	endtask

	task automatic check_pins(input logic c, input logic p, input logic [15:0] pat);
		{sp1_shared_out, cell_shared_out} = {4'(pat), 4'(~pat)};
		{sp1_shared_oe, cell_shared_oe} = {4'(pat >> 4), 4'(pat >> 8)};
		{host_shared_out, pci_shared_out} = {8'(pat), 8'(~pat)};
		{host_shared_oe, pci_shared_oe} = {8'(pat >> 3), 8'(pat >> 5)};
		{gpio_upper_out, pci_upper_out, pci_upper_oe} = {7'(pat >> 1), 7'(~pat), 7'(pat >> 7)};
		{gpio_pin_enable_bit, gpio_pin_direction_bit} = {7'(pat >> 2), 7'(pat >> 6)};
		{cell_solo_out, sp1_solo_out} = {2'(pat), 2'(~pat)};
		{pci_be0_drive, pci_be0_out, eeprom_cs_out} = pat[11:9];
		tick(1);
		chk("cs o", 16'(c ? cell_shared_out : sp1_shared_out), 16'(cs_shared_pin_o));
		chk("cs oe", 16'(c ? cell_shared_oe : sp1_shared_oe), 16'(cs_shared_pin_oe));
		chk("solo oe", 16'h0000, 16'(c ? sp1_solo_pin_oe : cell_solo_pin_oe));
		chk("solo live", 16'h0003, 16'(c ? cell_solo_pin_oe : sp1_solo_pin_oe));
		chk("solo o", 16'({cell_solo_out, sp1_solo_out}),
			16'({cell_solo_pin_o, sp1_solo_pin_o}));
		chk("hp o", 16'(p ? pci_shared_out : host_shared_out), 16'(hp_shared_pin_o));
		chk("hp oe", 16'(p ? pci_shared_oe : host_shared_oe), 16'(hp_shared_pin_oe));
		chk("gp o", 16'(p ? pci_upper_out : gpio_upper_out), 16'(gp_upper_pin_o));
		chk("gp oe", 16'(p ? pci_upper_oe : gpio_pin_enable_bit & gpio_pin_direction_bit),
			16'(gp_upper_pin_oe));
		chk("is gpio", 16'(p ? 7'h00 : gpio_pin_enable_bit), 16'(gpio_upper_is_gpio));
		chk("be0 oe", 16'(p && pci_be0_drive), 16'(pci_be0_pin_oe));
		chk("be0 cs o", 16'({pci_be0_out, eeprom_cs_out}),
			16'({pci_be0_pin_o, eeprom_cs_pin_o}));
	endtask

	initial begin
		for (int i = 0; i < 16; i++) begin
			start(i[3], i[2], i[1], i[0]);
			check_cfg(i[3], i[2], i[1]);
			check_pins(i[3], i[2], 16'h3c5a ^ 16'(i * 16'h1111));
			check_pins(i[3], i[2], 16'hc3a5 ^ 16'(i));
		end
		start(1'b1, 1'b1, 1'b0, 1'b1);
		{cell_w, eeprom_autoinit_strap_w} = 2'b00;
		tick(4);
		check_cfg(1'b1, 1'b1, 1'b0);
		sp2_w = 1'b1;
		tick(2);
		chk("port2 before sync", 16'h0000, 16'(serial_port2_enable));
		tick(1);
		check_cfg(1'b1, 1'b1, 1'b1);
		check_pins(1'b1, 1'b1, 16'h0f0f);
		sp2_w = 1'b0;
		tick(3);
		check_cfg(1'b1, 1'b1, 1'b0);
		end_sim();
	end
endmodule
